// file: src/host_port_pkg.sv
// shared constants for the host fifo port access block
package host_port_pkg;
	// host bus geometry: 16-bit transfers pair into 32-bit words
	localparam int          HALF_W      = 16;
	localparam int          WORD_W      = 32;
	localparam int          HADDR_W     = 7;
	// byte offsets of the ports and registers (low half at +0, high half at +2)
	localparam logic [7:0]  OFS_RX_DATA = 8'h00;
	localparam logic [7:0]  OFS_TX_DATA = 8'h40;
	localparam logic [7:0]  ALIAS_MASK  = 8'hC0;
	localparam logic [7:0]  OFS_RXS_POP = 8'h80;
	localparam logic [7:0]  OFS_RXS_PEEK = 8'h84;
	localparam logic [7:0]  OFS_TXS_POP = 8'h88;
	localparam logic [7:0]  OFS_TXS_PEEK = 8'h8C;
	localparam logic [7:0]  OFS_CTRL    = 8'h90;
	localparam logic [7:0]  OFS_STAT    = 8'h94;
	localparam logic [7:0]  OFS_WO      = 8'h98;
	localparam logic [7:0]  OFS_RO      = 8'h9C;
	localparam logic [7:0]  WORD_MASK   = 8'hFC;
	// control register layout
	localparam int          CTRL_SRST_BIT = 0;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
	localparam logic [31:0] CTRL_KEEP_MASK = 32'h0000_FF00;
	localparam logic [31:0] CTRL_USED_MASK = 32'h0000_FFFF;
	// status register layout
	localparam int          STAT_W1C_BIT = 0;
	localparam int          STAT_RC_BIT = 1;
	localparam int          STAT_LH_BIT = 2;
	localparam int          STAT_LL_BIT = 3;
	localparam int          STAT_LIVE_BIT = 4;
	// read-only register layout: receive status level high, transmit status level low
	localparam int          RO_RXS_LSB  = 16;
	localparam logic [31:0] WO_RESET    = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
	// host pin vector bit positions
	localparam int          PIN_CS      = 2;
	localparam int          PIN_RD      = 1;
	localparam int          PIN_WR      = 0;
endpackage

// file: src/port_fifo.sv
// one host-visible fifo with a registered head word and run-time size limit
`timescale 1ns/1ps
module port_fifo
	import host_port_pkg::*;
#(
	parameter int W     = 32,
	parameter int DEPTH = 16,
	parameter int CNT_W = $clog2(DEPTH + 1)
) (
	// clock, reset, enable
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic             ce,
	input  wire logic             flush,
	// run-time size
	input  wire logic [CNT_W-1:0] limit,
	// filling side
	input  wire logic             push_valid,
	input  wire logic [W-1:0]     push_data,
	output logic                  push_ready,
	// draining side
	input  wire logic             pop,
	output logic [W-1:0]          head,
	output logic                  head_valid,
	output logic [CNT_W-1:0]      count
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr_ptr;
		logic [AW-1:0]           rd_ptr;
		logic [CNT_W-1:0]        count;
		logic [W-1:0]            head;
	} fifo_s;

	fifo_s s;
	fifo_s next_s;
	logic  do_push;
	logic  do_pop;

	// full is honest: the run-time limit caps the fill level, and the array size caps it when the limit is larger
	assign push_ready = (s.count < limit) && (s.count < CNT_W'(DEPTH));
	assign head_valid = (s.count != '0);
	assign head       = s.head;
	assign count      = s.count;
	assign do_push    = push_valid && push_ready;
	assign do_pop     = pop && head_valid;

	// next state; head is re-read after the write so an empty fifo shows new data
	always_comb begin
		next_s = s;
		if (ce) begin
			if (flush) begin
				next_s.wr_ptr = '0;
				next_s.rd_ptr = '0;
				next_s.count  = '0;
			end else begin
				if (do_push) begin
					next_s.mem[s.wr_ptr] = push_data;
					next_s.wr_ptr = s.wr_ptr + AW'(1);
				end
				if (do_pop) begin
					next_s.rd_ptr = s.rd_ptr + AW'(1);
				end
				next_s.count = s.count + CNT_W'(do_push) - CNT_W'(do_pop);
			end
			next_s.head = next_s.mem[next_s.rd_ptr];
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// file: src/host_fifo_port_access.sv
// host access layer: 16-bit host bus onto 32-bit fifo ports and attribute registers
// Notes on behaviour
// [R1] host halves pair into one 32-bit access
// [R2] writes to read-only register are ignored
// [R3] write-only register always reads zero
// [R4] writing one clears bit, zero keeps
// [R5] reading the register clears the bit
// [R6] latched bits hold until register read
// [R7] every reset loads register defaults
// [R8] kept bits survive software reset only
// [R9] host writes zeros to reserved bits
// [R10] host never writes reserved locations
// [R11] four fifos, sizes set at run time (tx status fifo here is fixed at DEPTH_TXS)
// [R12] receive fifos are read only
// [R13] status pop port returns and removes
// [R14] status peek port returns, keeps entry
// [R15] data port read removes oldest word
// [R16] receive data at sixteen aliased words
// [R17] transmit status pop returns and removes
// [R18] transmit status peek leaves fifo unchanged
// [R19] transmit data written at sixteen aliases
// [R20] pop or push only on second half
// [R21] self-clearing bit drops after acting
`timescale 1ns/1ps
module host_fifo_port_access
	import host_port_pkg::*;
#(
	parameter int DEPTH_RXD = 16,
	parameter int DEPTH_RXS = 8,
	parameter int DEPTH_TXD = 16,
	parameter int DEPTH_TXS = 8,
	parameter int CNT_W     = 5
) (
	// clock, reset, enable
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	input  wire logic               ce,
	// host bus pins
	input  wire logic               host_cs_n,
	input  wire logic               host_rd_n,
	input  wire logic               host_wr_n,
	input  wire logic [HADDR_W-1:0] host_addr,
	input  wire logic [HALF_W-1:0]  host_data_in,
	output logic      [HALF_W-1:0]  host_data_out,
	output logic                    host_data_oe_n,
	// run-time fifo sizes
	input  wire logic [CNT_W-1:0]   rxd_size,
	input  wire logic [CNT_W-1:0]   rxs_size,
	input  wire logic [CNT_W-1:0]   txd_size,
	// receive side filling
	input  wire logic [WORD_W-1:0]  rxd_in,
	input  wire logic               rxd_in_valid,
	output logic                    rxd_in_ready,
	input  wire logic [WORD_W-1:0]  rxs_in,
	input  wire logic               rxs_in_valid,
	output logic                    rxs_in_ready,
	// transmit side
	output logic      [WORD_W-1:0]  txd_out,
	output logic                    txd_out_valid,
	input  wire logic               txd_out_ready,
	input  wire logic [WORD_W-1:0]  txs_in,
	input  wire logic               txs_in_valid,
	output logic                    txs_in_ready,
	// attribute register events and outputs
	input  wire logic               ev_clear_on_write,
	input  wire logic               ev_clear_on_read,
	input  wire logic               link_level,
	output logic      [WORD_W-1:0]  ctrl_value,
	output logic      [WORD_W-1:0]  wo_value,
	output logic                    soft_reset_pulse
);
	typedef struct packed {
		logic [2:0]         pin1;
		logic [2:0]         pin2;
		logic [HADDR_W-1:0] addr1;
		logic [HADDR_W-1:0] addr2;
		logic [HALF_W-1:0]  data1;
		logic [HALF_W-1:0]  data2;
		logic               rd_prev;
		logic               wr_prev;
		logic               drive;
		logic [HALF_W-1:0]  rdata;
		logic [WORD_W-1:0]  hold;
		logic [HALF_W-1:0]  wr_low;
		logic [WORD_W-1:0]  ctrl;
		logic [WORD_W-1:0]  wo;
		logic               w1c;
		logic               rc;
		logic               lh;
		logic               ll;
	} host_s;

	host_s              s;
	host_s              next_s;
	logic [7:0]         byte_addr;
	logic [7:0]         word_addr;
	logic               hi_half;
	logic               rd_act;
	logic               wr_act;
	logic               rd_start;
	logic               wr_start;
	logic               sel_rxd;
	logic               sel_txd;
	logic [WORD_W-1:0]  word_in;
	logic [WORD_W-1:0]  rd_word;
	logic               srst;
	logic               rxd_pop;
	logic               rxs_pop;
	logic               txs_pop;
	logic               txd_push;
	logic               txd_ready;
	logic [WORD_W-1:0]  rxd_head;
	logic [WORD_W-1:0]  rxs_head;
	logic [WORD_W-1:0]  txs_head;
	logic               rxd_hv;
	logic               rxs_hv;
	logic               txs_hv;
	logic [CNT_W-1:0]   rxs_cnt;
	logic [CNT_W-1:0]   txs_cnt;

	// decode from the second synchroniser stage only
	assign byte_addr = {s.addr2, 1'b0};
	assign word_addr = byte_addr & WORD_MASK;
	assign hi_half   = byte_addr[1];
	assign rd_act    = !s.pin2[PIN_CS] && !s.pin2[PIN_RD];
	assign wr_act    = !s.pin2[PIN_CS] && !s.pin2[PIN_WR];
	assign rd_start  = rd_act && !s.rd_prev;
	assign wr_start  = wr_act && !s.wr_prev;
	assign word_in   = {s.data2, s.wr_low};
	assign srst      = s.ctrl[CTRL_SRST_BIT];
	// [R16] receive data aliases
	assign sel_rxd   = (byte_addr & ALIAS_MASK) == OFS_RX_DATA;
	// [R19] transmit data aliases
	assign sel_txd   = (byte_addr & ALIAS_MASK) == OFS_TX_DATA;

	// [R13] [R15] [R17] [R20] pops fire on the high-half read only
	assign rxd_pop  = rd_start && hi_half && sel_rxd;
	assign rxs_pop  = rd_start && hi_half && (word_addr == OFS_RXS_POP);
	assign txs_pop  = rd_start && hi_half && (word_addr == OFS_TXS_POP);
	// [R20] push only once both halves written; full fifo drops the word
	assign txd_push = wr_start && hi_half && sel_txd;

	// outputs
	assign host_data_out    = s.rdata;
	assign host_data_oe_n   = !s.drive;
	assign ctrl_value       = s.ctrl;
	assign wo_value         = s.wo;
	assign soft_reset_pulse = srst;

	// [R11] four fifos; rx data, rx status and tx data sized at run time, tx status fixed at DEPTH_TXS
	port_fifo #(.W(WORD_W), .DEPTH(DEPTH_RXD), .CNT_W(CNT_W)) u_rxd (
		.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .flush(srst), .limit(rxd_size),
		.push_valid(rxd_in_valid), .push_data(rxd_in), .push_ready(rxd_in_ready),
		.pop(rxd_pop), .head(rxd_head), .head_valid(rxd_hv), .count()
	);
	port_fifo #(.W(WORD_W), .DEPTH(DEPTH_RXS), .CNT_W(CNT_W)) u_rxs (
		.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .flush(srst), .limit(rxs_size),
		.push_valid(rxs_in_valid), .push_data(rxs_in), .push_ready(rxs_in_ready),
		.pop(rxs_pop), .head(rxs_head), .head_valid(rxs_hv), .count(rxs_cnt)
	);
	// transmit data: host fills, the transmit side drains with back-pressure
	port_fifo #(.W(WORD_W), .DEPTH(DEPTH_TXD), .CNT_W(CNT_W)) u_txd (
		.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .flush(srst), .limit(txd_size),
		.push_valid(txd_push), .push_data(word_in), .push_ready(txd_ready),
		.pop(txd_out_ready), .head(txd_out), .head_valid(txd_out_valid), .count()
	);
	port_fifo #(.W(WORD_W), .DEPTH(DEPTH_TXS), .CNT_W(CNT_W)) u_txs (
		.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .flush(srst),
		.limit(CNT_W'(DEPTH_TXS)),
		.push_valid(txs_in_valid), .push_data(txs_in), .push_ready(txs_in_ready),
		.pop(txs_pop), .head(txs_head), .head_valid(txs_hv), .count(txs_cnt)
	);

	// read word mux; empty fifos read as zero, unmapped as zero
	always_comb begin
		rd_word = ZERO_WORD;
		if (sel_rxd) begin
			rd_word = rxd_hv ? rxd_head : ZERO_WORD;
		end else if (word_addr == OFS_RXS_POP || word_addr == OFS_RXS_PEEK) begin
			// [R14] peek shares the head, never pops
			rd_word = rxs_hv ? rxs_head : ZERO_WORD;
		end else if (word_addr == OFS_TXS_POP || word_addr == OFS_TXS_PEEK) begin
			// [R18] peek shares the head, never pops
			rd_word = txs_hv ? txs_head : ZERO_WORD;
		end else if (word_addr == OFS_CTRL) begin
			rd_word = s.ctrl;
		end else if (word_addr == OFS_STAT) begin
			rd_word[STAT_W1C_BIT]  = s.w1c;
			rd_word[STAT_RC_BIT]   = s.rc;
			rd_word[STAT_LH_BIT]   = s.lh;
			rd_word[STAT_LL_BIT]   = s.ll;
			rd_word[STAT_LIVE_BIT] = link_level;
		end else if (word_addr == OFS_RO) begin
			rd_word = (WORD_W'(rxs_cnt) << RO_RXS_LSB) | WORD_W'(txs_cnt);
		end else begin
			// [R3] write-only and reserved words read zero
			rd_word = ZERO_WORD;
		end
	end

	// next state of the host side
	always_comb begin
		next_s = s;
		if (ce) begin
			// host pins are asynchronous: two stages before any decode
			next_s.pin1    = {host_cs_n, host_rd_n, host_wr_n};
			next_s.pin2    = s.pin1;
			next_s.addr1   = host_addr;
			next_s.addr2   = s.addr1;
			next_s.data1   = host_data_in;
			next_s.data2   = s.data1;
			next_s.rd_prev = rd_act;
			next_s.wr_prev = wr_act;
			next_s.drive   = rd_act;
			// [R1] low half latches the whole word, high half returns its top
			if (rd_start) begin
				if (!hi_half) begin
					next_s.hold  = rd_word;
					next_s.rdata = rd_word[HALF_W-1:0];
				end else begin
					next_s.rdata = s.hold[WORD_W-1:HALF_W];
				end
			end
			// [R6] latches follow the input only when released by a read
			if (link_level) begin
				next_s.lh = 1'b1;
			end
			if (!link_level) begin
				next_s.ll = 1'b0;
			end
			if (rd_start && !hi_half && word_addr == OFS_STAT) begin
				next_s.lh = link_level;
				next_s.ll = link_level;
				// [R5] read clears
				next_s.rc = 1'b0;
			end
			// [R1] low half parks until the high half completes the word
			if (wr_start && !hi_half) begin
				next_s.wr_low = s.data2;
			end
			if (wr_start && hi_half) begin
				if (word_addr == OFS_CTRL) begin
					next_s.ctrl = word_in & CTRL_USED_MASK;
				end else if (word_addr == OFS_WO) begin
					next_s.wo = word_in;
				end else if (word_addr == OFS_STAT && word_in[STAT_W1C_BIT]) begin
					// [R4] one clears, zero leaves alone
					next_s.w1c = 1'b0;
				end
				// [R2] [R12] read-only word, receive ports and reserved words ignore writes
			end
			// events win over a host write-one or read clear in the same cycle
			if (ev_clear_on_write) begin
				next_s.w1c = 1'b1;
			end
			if (ev_clear_on_read) begin
				next_s.rc = 1'b1;
			end
			// [R7] [R8] [R21] software reset acts for one cycle, then clears itself
			if (srst) begin
				next_s.ctrl  = (s.ctrl & CTRL_KEEP_MASK) | (CTRL_RESET & ~CTRL_KEEP_MASK);
				next_s.wo    = WO_RESET;
				next_s.hold  = ZERO_WORD;
				next_s.w1c   = 1'b0;
				next_s.rc    = 1'b0;
				next_s.lh    = 1'b0;
				next_s.ll    = 1'b1;
			end
		end
	end

	// [R7] power-on and system reset load defaults
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s       <= '0;
			s.pin1  <= 3'h7;
			s.pin2  <= 3'h7;
			s.ctrl  <= CTRL_RESET;
			s.wo    <= WO_RESET;
			s.ll    <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// assertion helpers
	sequence seq_stat_low_read;
		rd_start && !hi_half && word_addr == OFS_STAT && ce;
	endsequence
	sequence seq_stat_high_write;
		wr_start && hi_half && word_addr == OFS_STAT && ce;
	endsequence

	AST_RO_IGNORES: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R2]
		(wr_start && hi_half && word_addr == OFS_RO && ce && !srst)
		|=> ($stable(s.ctrl) && $stable(s.wo)))
		else $error("write to read-only word changed a register");
	AST_WO_READS_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R3]
		(rd_start && word_addr == OFS_WO && ce) |=> (s.rdata == '0))
		else $error("write-only word did not read zero");
	AST_W1C: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R4]
		(seq_stat_high_write and (word_in[STAT_W1C_BIT] && !ev_clear_on_write))
		|=> !s.w1c)
		else $error("write one did not clear the bit");
	AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R5]
		(ev_clear_on_read && ce && !srst) |=> s.rc)
		else $error("read-clear bit lost a set event");
	AST_RC: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R5]
		(seq_stat_low_read and (!ev_clear_on_read && !srst)) |=> !s.rc)
		else $error("read did not clear the bit");
	AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R6]
		(s.lh && ce && !srst && !(rd_start && !hi_half && word_addr == OFS_STAT)) |=> s.lh)
		else $error("latched bit released without a read");
	AST_SC: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R21]
		(srst && ce) |=> (!srst && s.wo == WO_RESET))
		else $error("self-clearing reset did not act and drop");
	AST_KEEP: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R8]
		(srst && ce) |=> ((s.ctrl & CTRL_KEEP_MASK) == ($past(s.ctrl) & CTRL_KEEP_MASK)))
		else $error("kept bits changed on software reset");
	AST_PEEK: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R14]
		(rd_start && word_addr == OFS_RXS_PEEK && ce && !srst && !rxs_in_valid)
		|=> $stable(rxs_cnt))
		else $error("peek port changed the fifo level");
	AST_POP_PAIR: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R20]
		(rxd_pop || rxs_pop || txs_pop || txd_push) |-> hi_half)
		else $error("fifo moved on a low-half access");
endmodule

// file: testbench/host_bus_model.sv
// host cpu model: drives the 16-bit strobed host bus one halfword per access
`timescale 1ns/1ps
module host_bus_model
	import host_port_pkg::*;
(
	// clock
	input  wire logic               clk_sys,
	// host bus pins
	output logic                    host_cs_n,
	output logic                    host_rd_n,
	output logic                    host_wr_n,
	output logic      [HADDR_W-1:0] host_addr,
	output logic      [HALF_W-1:0]  host_data_in,
	input  wire logic [HALF_W-1:0]  host_data_out,
	input  wire logic               host_data_oe_n
);
	logic [HALF_W-1:0] drive = 16'h0000;
	logic              driving = 1'b0;
	logic [HALF_W-1:0] last = 16'h0000;

	// wire level: device while it drives, host on writes, else a float that keeps moving
	assign host_data_in = !host_data_oe_n ? host_data_out : (driving ? drive : ~last);

	// remember the wire so an undriven bus never shows a stale value
	always @(posedge clk_sys) begin
		last <= host_data_in;
	end

	initial begin
		host_cs_n = 1'b1;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		host_addr = '0;
	end

	// only mapped words are touched; one halfword per strobe
	task automatic access(input logic wr, input logic [7:0] ofs, input logic [15:0] wd,
		output logic [15:0] rd);
		@(posedge clk_sys);
		#2;
		host_addr = ofs[7:1];
		drive = wd;
		driving = wr;
		host_cs_n = 1'b0;
		host_rd_n = wr;
		host_wr_n = !wr;
		// strobe held five cycles so the synced access and answer both land
		repeat (5) @(posedge clk_sys);
		rd = host_data_out;
		#2;
		host_cs_n = 1'b1;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		driving = 1'b0;
		// idle gap lets the synced strobe fall before the next access
		repeat (3) @(posedge clk_sys);
		// return off the edge so the caller's next input change never races the clock
		#2;
	endtask
endmodule

// file: testbench/host_fifo_port_access_tb_top.sv
// self-checking bench for the host fifo port access block
`timescale 1ns/1ps
module host_fifo_port_access_tb_top
	import host_port_pkg::*;
;
	logic               clk_sys = 1'b0;
	logic               reset_n = 1'b0;
	logic               host_cs_n, host_rd_n, host_wr_n;
	logic [HADDR_W-1:0] host_addr;
	logic [HALF_W-1:0]  host_data_in, host_data_out;
	logic               host_data_oe_n;
	logic [WORD_W-1:0]  rxd_in = '0, rxs_in = '0, txs_in = '0, txd_out, ctrl_value, wo_value;
	logic               rxd_in_valid = 0, rxs_in_valid = 0, txs_in_valid = 0, txd_out_ready = 0;
	logic               rxd_in_ready, rxs_in_ready, txs_in_ready, txd_out_valid;
	logic               ev_clear_on_write = 0, ev_clear_on_read = 0, link_level = 1;
	logic               soft_reset_pulse;
	logic [4:0]         rxd_size = 5'd16;
	int                 err_total = 0, checks_done = 0, pulses = 0, p0, n;
	logic [31:0]        w, r, q[$];
	logic [7:0]         a;

	always #50 clk_sys = ~clk_sys;

	// count soft reset pulses so their width can be judged afterwards
	always @(posedge clk_sys) begin
		if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
	end

	host_bus_model hbm (.clk_sys(clk_sys), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n));

	host_fifo_port_access DUT (.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1),
		.host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
		.host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe_n(host_data_oe_n), .rxd_size(rxd_size), .rxs_size(5'd8), .txd_size(5'd16),
		.rxd_in(rxd_in), .rxd_in_valid(rxd_in_valid), .rxd_in_ready(rxd_in_ready),
		.rxs_in(rxs_in), .rxs_in_valid(rxs_in_valid), .rxs_in_ready(rxs_in_ready),
		.txd_out(txd_out), .txd_out_valid(txd_out_valid), .txd_out_ready(txd_out_ready),
		.txs_in(txs_in), .txs_in_valid(txs_in_valid), .txs_in_ready(txs_in_ready),
		.ev_clear_on_write(ev_clear_on_write), .ev_clear_on_read(ev_clear_on_read),
		.link_level(link_level), .ctrl_value(ctrl_value), .wo_value(wo_value),
		.soft_reset_pulse(soft_reset_pulse));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// a bounded wait that ran out ends the run
	task automatic bound(input int cnt);
		if (cnt >= 20) begin
			err_total++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			give_verdict();
		end
	endtask

	// whole words always go low half first, then high half
	task automatic wr32(input logic [7:0] ofs, input logic [31:0] d);
		logic [15:0] x;
		hbm.access(1'b1, ofs, d[15:0], x);
		hbm.access(1'b1, ofs + 8'h02, d[31:16], x);
	endtask

	task automatic rd32(input logic [7:0] ofs, output logic [31:0] d);
		logic [15:0] lo, hi;
		hbm.access(1'b0, ofs, 16'h0000, lo);
		hbm.access(1'b0, ofs + 8'h02, 16'h0000, hi);
		d = {hi, lo};
	endtask

	// push one word into rx data (0), rx status (1) or tx status (2)
	task automatic fill(input int sel, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		#2;
		rxd_in = d;
		rxs_in = d;
		txs_in = d;
		rxd_in_valid = (sel == 0);
		rxs_in_valid = (sel == 1);
		txs_in_valid = (sel == 2);
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (!(sel == 0 ? rxd_in_ready : sel == 1 ? rxs_in_ready : txs_in_ready) && k < 20);
		#2;
		{rxd_in_valid, rxs_in_valid, txs_in_valid} = 3'b000;
		bound(k);
	endtask

	task automatic pulse_event(input logic on_write);
		@(posedge clk_sys);
		#2;
		if (on_write) ev_clear_on_write = 1'b1;
		else ev_clear_on_read = 1'b1;
		@(posedge clk_sys);
		#2;
		{ev_clear_on_write, ev_clear_on_read} = 2'b00;
	endtask

	// expected read of the count register; counts of depth 8 fit easily
	function automatic logic [31:0] ro_word(input int rxs, input int txs);
		return {16'(rxs), 16'(txs)};
	endfunction

	// control bits that live on after a software reset
	function automatic logic [31:0] ctrl_after_soft(input logic [31:0] v);
		return v & CTRL_KEEP_MASK;
	endfunction

	initial begin
		void'($urandom(32'h2f0d9c0b));
		repeat (2) @(posedge clk_sys);
		#2;
		reset_n = 1'b1;
		// latch bits and defaults
		rd32(OFS_CTRL, r);
		chk(r, CTRL_RESET, "ctrl default");
		link_level = 1'b0;
		repeat (2) @(posedge clk_sys);
		#2;
		link_level = 1'b1;
		rd32(OFS_STAT, r);
		chk(r, 32'h0000_0014, "latched low kept");
		rd32(OFS_STAT, r);
		chk(r, 32'h0000_001C, "latch released");
		pulse_event(1'b1);
		wr32(OFS_STAT, 32'h0000_0000);
		rd32(OFS_STAT, r);
		chk(r, 32'h0000_001D, "zero write keeps");
		wr32(OFS_STAT, 32'h0000_0001);
		rd32(OFS_STAT, r);
		chk(r, 32'h0000_001C, "one write clears");
		pulse_event(1'b0);
		rd32(OFS_STAT, r);
		chk(r, 32'h0000_001E, "read clear set");
		rd32(OFS_STAT, r);
		chk(r, 32'h0000_001C, "read clear gone");
		$display("test status done");
		// rx data through random aliases, with a refused write among it
		repeat (5) begin
			w = $urandom();
			q.push_back(w);
			fill(0, w);
		end
		wr32(8'h04, 32'h1234_5678);
		foreach (q[k]) begin
			a = {2'b00, 4'($urandom_range(15)), 2'b00};
			rd32(a, r);
			chk(r, q[k], "rx data pop");
		end
		rd32(8'h3C, r);
		chk(r, ZERO_WORD, "rx data empty");
		// a run-time limit of two words makes the fifo full early
		rxd_size = 5'd2;
		fill(0, 32'h0000_00A1);
		fill(0, 32'h0000_00A2);
		chk(32'(rxd_in_ready), 32'd0, "size limit full");
		rd32(8'h00, r);
		chk(r, 32'h0000_00A1, "limited fifo head");
		rd32(8'h00, r);
		chk(r, 32'h0000_00A2, "limited fifo tail");
		rxd_size = 5'd16;
		q.delete();
		$display("test rx data done");
		// status fifos: peek keeps, pop removes; count register ignores writes
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 2 + s; k++) fill(2 - s, 32'h0000_0100 * (s + 1) + 32'(k));
		end
		wr32(OFS_RO, $urandom());
		rd32(OFS_RO, r);
		chk(r, ro_word(3, 2), "count register");
		for (int s = 0; s < 2; s++) begin
			a = s ? OFS_TXS_POP : OFS_RXS_POP;
			w = s ? 32'h0000_0100 : 32'h0000_0200;
			rd32(a + 8'h04, r);
			chk(r, w, "peek head");
			rd32(a + 8'h04, r);
			chk(r, w, "peek again");
			rd32(a, r);
			chk(r, w, "pop head");
			rd32(a + 8'h04, r);
			chk(r, w + 32'h0000_0001, "next after pop");
		end
		$display("test status fifos done");
		// tx data written at random aliases while the drain side stalls
		repeat (4) begin
			w = $urandom();
			q.push_back(w);
			wr32({2'b01, 4'($urandom_range(15)), 2'b00}, w);
		end
		foreach (q[k]) begin
			n = 0;
			while (txd_out_valid !== 1'b1 && n < 20) begin
				@(posedge clk_sys);
				#2;
				n++;
			end
			bound(n);
			chk(txd_out, q[k], "tx data order");
			txd_out_ready = 1'b1;
			@(posedge clk_sys);
			#2;
			txd_out_ready = 1'b0;
			@(posedge clk_sys);
			#2;
		end
		$display("test tx data done");
		// registers: write-only, read/write, then software reset
		w = $urandom();
		wr32(OFS_WO, w);
		chk(wo_value, w, "write-only stored");
		rd32(OFS_WO, r);
		chk(r, ZERO_WORD, "write-only reads zero");
		w = $urandom() & 32'h0000_FFFE; // reserved upper bits written as zero
		wr32(OFS_CTRL, w);
		rd32(OFS_CTRL, r);
		chk(r, w, "ctrl readback");
		p0 = pulses;
		w = w | 32'h0000_0001;
		wr32(OFS_CTRL, w);
		chk(32'(pulses - p0), 32'd1, "one soft reset pulse");
		chk(ctrl_value, ctrl_after_soft(w), "kept ctrl bits");
		chk(wo_value, WO_RESET, "wo soft reset");
		$display("test registers done");
		// hard reset in mid-run clears kept bits too
		reset_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(ctrl_value, CTRL_RESET, "ctrl hard reset");
		#2;
		reset_n = 1'b1;
		rd32(OFS_CTRL, r);
		chk(r, CTRL_RESET, "ctrl after reset");
		$display("test hard reset done");
		give_verdict();
	end
endmodule
